// ---- rtl/stop_ctrl_consts.svh ----
// Constants for the stop-mode power controller: mode encodings, vector
// addresses and wake-timer counts. Assumes a 250 MHz core clock.
`ifndef STOP_CTRL_CONSTS_SVH
`define STOP_CTRL_CONSTS_SVH

// Requested stop depth codes (software stop select field)
`define STOP_REQ_STOP3 2'h0
`define STOP_REQ_STOP2 2'h1
`define STOP_REQ_STOP1 2'h2

// Vector addresses handed to the core on wake
`define VEC_RESET 16'hfffe
`define VEC_IRQ 16'hfffa
`define VEC_KEYBOARD 16'hffd2
`define VEC_PERIODIC 16'hffcc

// Core clock and wake timer source
`define CORE_CLK_MHZ 250
`define WAKE_SRC_KHZ 1
// Core cycles per tick of the self-clocked wake source
`define WAKE_TICK_CYCLES ((`CORE_CLK_MHZ * 1000) / `WAKE_SRC_KHZ)
`define WAKE_TICK_W 18

`endif

// ---- rtl/stop_ctrl_pkg.sv ----
// Types shared by the stop-mode power controller.
// Assumes the constants header is included by users of the encodings.
package stop_ctrl_pkg;

	typedef enum logic [1:0] {
		MODE_RUN,
		MODE_STOP3,
		MODE_STOP2,
		MODE_STOP1
	} stop_mode_t;

	typedef enum logic [2:0] {
		WAKE_NONE,
		WAKE_RESET,
		WAKE_IRQ,
		WAKE_KEYBOARD,
		WAKE_PERIODIC,
		WAKE_DEBUG
	} wake_cause_t;

	// Power and clock controls driven to the rest of the chip
	typedef struct packed {
		logic core_clk_run;
		logic periph_clk_run;
		logic debug_clk_run;
		logic clkgen_on;
		logic clkgen_standby;
		logic clkgen_keep_ref;
		logic regulator_full;
		logic converter_standby;
		logic pins_latched;
		logic pins_force_reset;
		logic ram_keep;
		logic keyboard_wake_en;
	} power_ctrl_t;

	// Wake answer to the core
	typedef struct packed {
		logic wake;
		logic take_reset;
		logic [15:0] vector;
		logic periph_reset;
	} wake_out_t;

endpackage

// ---- rtl/stop_mode_power_control.sv ----
// Stop-mode power controller: picks the effective stop depth, drives the
// clock, regulator, pin and peripheral controls and resolves wake events.
// Assumes all inputs are synchronous to i_core_clk; wake pins arrive here
// already reduced to clean levels by the pad logic.
`timescale 1ns/1ps
`default_nettype none
`include "stop_ctrl_consts.svh"

module stop_mode_power_control #(
	parameter int unsigned WAKE_TICK_CYCLES = `WAKE_TICK_CYCLES
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_stop_instr,
	input wire logic i_stop_enable_bit,
	input wire logic [1:0] i_stop_select,
	input wire logic i_debug_mode_enable,
	input wire logic i_low_voltage_detect_enable,
	input wire logic i_low_voltage_detect_stop_enable,
	input wire logic i_clkgen_keep_ref,
	input wire logic [2:0] i_wakeup_period_select,
	input wire logic i_reset_pin_n,
	input wire logic i_irq_pin,
	input wire logic [7:0] i_keyboard_pins,
	input wire logic [7:0] i_keyboard_enable,
	input wire logic i_debug_background_cmd,
	input wire logic i_debug_mem_status_cmd,
	input wire logic i_partial_powerdown_acknowledge,
	output logic o_illegal_opcode_reset,
	output stop_ctrl_pkg::power_ctrl_t o_power,
	output stop_ctrl_pkg::wake_out_t o_wake,
	output logic o_in_stop,
	output stop_ctrl_pkg::stop_mode_t o_stop_mode,
	output logic o_debug_mem_grant,
	output logic o_debug_stop_error,
	output logic o_background_entry,
	output logic o_stop2_recovery_flag,
	output logic o_wake_tick_running,
	output logic o_periodic_wakeup_interrupt
);

	// ---------------------------------------------------------------
	// Reset synchroniser
	// ---------------------------------------------------------------
	logic rst_meta_q;
	logic rst_sync_q;
	logic rstn;

	// Two stages so release is clean relative to the core clock
	always_ff @(posedge i_core_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			rst_meta_q <= 1'b0;
			rst_sync_q <= 1'b0;
		end else begin
			rst_meta_q <= 1'b1;
			rst_sync_q <= rst_meta_q;
		end
	end
	assign rstn = rst_sync_q;

	// ---------------------------------------------------------------
	// Effective mode selection
	// ---------------------------------------------------------------
	stop_ctrl_pkg::stop_mode_t mode_q;
	stop_ctrl_pkg::stop_mode_t mode_d;
	logic dbg_q;
	logic lvd_q;
	logic lvd_stop_q;
	logic keep_ref_q;
	logic enter;
	logic wake_any;
	stop_ctrl_pkg::wake_cause_t cause_d;

	// Debug or voltage watch forbids the deeper modes
	function automatic stop_ctrl_pkg::stop_mode_t pick_mode(input logic [1:0] sel, input logic dbg,
			input logic lvd_stop);
		stop_ctrl_pkg::stop_mode_t m;
		m = stop_ctrl_pkg::MODE_STOP3;
		if (!dbg && !lvd_stop) begin
			if (sel == `STOP_REQ_STOP2)
				m = stop_ctrl_pkg::MODE_STOP2;
			else if (sel == `STOP_REQ_STOP1)
				m = stop_ctrl_pkg::MODE_STOP1;
		end
		return m;
	endfunction

	assign enter = i_stop_instr && i_stop_enable_bit && (mode_q == stop_ctrl_pkg::MODE_RUN);
	assign mode_d = pick_mode(i_stop_select, i_debug_mode_enable, i_low_voltage_detect_stop_enable);

	// Illegal stop pulses a reset request and never enters a stop mode
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn)
			o_illegal_opcode_reset <= 1'b0;
		else
			o_illegal_opcode_reset <= i_stop_instr && !i_stop_enable_bit && (mode_q == stop_ctrl_pkg::MODE_RUN);
	end

	// Settings captured at the stop instruction stay fixed for the whole stop
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn) begin
			dbg_q <= 1'b0;
			lvd_q <= 1'b0;
			lvd_stop_q <= 1'b0;
			keep_ref_q <= 1'b0;
		end else if (enter) begin
			dbg_q <= i_debug_mode_enable;
			lvd_q <= i_low_voltage_detect_enable;
			lvd_stop_q <= i_low_voltage_detect_stop_enable;
			keep_ref_q <= i_clkgen_keep_ref;
		end
	end

	// ---------------------------------------------------------------
	// Self-clocked wake tick
	// ---------------------------------------------------------------
	logic [`WAKE_TICK_W-1:0] tick_cnt_q;
	logic tick_run;
	logic tick;

	assign tick_run = (i_wakeup_period_select != 3'h0);
	assign tick = tick_run && (tick_cnt_q == `WAKE_TICK_W'(WAKE_TICK_CYCLES - 1));

	// Runs through every mode since it is its own clock source; held in clear when off
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn)
			tick_cnt_q <= '0;
		else if (!tick_run || tick)
			tick_cnt_q <= '0;
		else
			tick_cnt_q <= tick_cnt_q + `WAKE_TICK_W'(1);
	end

	// ---------------------------------------------------------------
	// Wake resolution
	// ---------------------------------------------------------------
	logic kb_hit;
	logic dbg_wake;

	assign kb_hit = |(i_keyboard_pins & i_keyboard_enable) && (mode_q == stop_ctrl_pkg::MODE_STOP3);
	assign dbg_wake = i_debug_background_cmd && dbg_q;

	// Reset pin outranks every interrupt source; keyboard wakes only stop3 and the tick never wakes stop1
	always_comb begin
		cause_d = stop_ctrl_pkg::WAKE_NONE;
		if (!i_reset_pin_n)
			cause_d = stop_ctrl_pkg::WAKE_RESET;
		else if (i_irq_pin)
			cause_d = stop_ctrl_pkg::WAKE_IRQ;
		else if (kb_hit)
			cause_d = stop_ctrl_pkg::WAKE_KEYBOARD;
		else if (tick && mode_q != stop_ctrl_pkg::MODE_STOP1)
			cause_d = stop_ctrl_pkg::WAKE_PERIODIC;
		else if (dbg_wake)
			cause_d = stop_ctrl_pkg::WAKE_DEBUG;
	end
	assign wake_any = (mode_q != stop_ctrl_pkg::MODE_RUN) && (cause_d != stop_ctrl_pkg::WAKE_NONE);

	// Mode register
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn)
			mode_q <= stop_ctrl_pkg::MODE_RUN;
		else if (enter)
			mode_q <= mode_d;
		else if (wake_any)
			mode_q <= stop_ctrl_pkg::MODE_RUN;
	end

	// Wake answer: deep stops always restart through the reset vector
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn) begin
			o_wake <= '0;
			o_background_entry <= 1'b0;
		end else begin
			o_wake <= '0;
			o_background_entry <= 1'b0;
			if (wake_any) begin
				o_wake.wake <= 1'b1;
				if (mode_q != stop_ctrl_pkg::MODE_STOP3) begin
					o_wake.take_reset <= 1'b1;
					o_wake.periph_reset <= 1'b1;
					o_wake.vector <= `VEC_RESET;
				end else begin
					case (cause_d)
						stop_ctrl_pkg::WAKE_RESET: begin
							o_wake.take_reset <= 1'b1;
							o_wake.vector <= `VEC_RESET;
						end
						stop_ctrl_pkg::WAKE_IRQ: o_wake.vector <= `VEC_IRQ;
						stop_ctrl_pkg::WAKE_KEYBOARD: o_wake.vector <= `VEC_KEYBOARD;
						stop_ctrl_pkg::WAKE_PERIODIC: o_wake.vector <= `VEC_PERIODIC;
						stop_ctrl_pkg::WAKE_DEBUG: o_background_entry <= 1'b1;
						default: o_wake.vector <= `VEC_RESET;
					endcase
				end
			end
		end
	end

	// ---------------------------------------------------------------
	// Stop2 pin latch and recovery flag
	// ---------------------------------------------------------------
	logic recov_q;

	// Entry sets the latch; acknowledge clears it, but a fresh stop2 entry wins
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn)
			recov_q <= 1'b0;
		else if (enter && mode_d == stop_ctrl_pkg::MODE_STOP2)
			recov_q <= 1'b1;
		else if (i_partial_powerdown_acknowledge && mode_q == stop_ctrl_pkg::MODE_RUN)
			recov_q <= 1'b0;
	end

	// Flag only shows once the core is running again
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn)
			o_stop2_recovery_flag <= 1'b0;
		else
			o_stop2_recovery_flag <= recov_q && (mode_q == stop_ctrl_pkg::MODE_RUN);
	end

	// ---------------------------------------------------------------
	// Power and clock controls
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn) begin
			o_power <= '0;
			o_power.core_clk_run <= 1'b1;
			o_power.periph_clk_run <= 1'b1;
			o_power.debug_clk_run <= 1'b1;
			o_power.clkgen_on <= 1'b1;
			o_power.regulator_full <= 1'b1;
			o_power.ram_keep <= 1'b1;
		end else begin
			o_power.pins_latched <= recov_q;
			o_power.keyboard_wake_en <= 1'b1;
			case (mode_q)
				stop_ctrl_pkg::MODE_RUN: begin
					o_power.core_clk_run <= 1'b1;
					o_power.periph_clk_run <= 1'b1;
					o_power.debug_clk_run <= 1'b1;
					o_power.clkgen_on <= 1'b1;
					o_power.clkgen_standby <= 1'b0;
					o_power.clkgen_keep_ref <= 1'b0;
					o_power.regulator_full <= 1'b1;
					o_power.converter_standby <= 1'b0;
					o_power.pins_force_reset <= 1'b0;
					o_power.ram_keep <= 1'b1;
				end
				stop_ctrl_pkg::MODE_STOP3: begin
					o_power.core_clk_run <= 1'b0;
					o_power.periph_clk_run <= 1'b0;
					o_power.debug_clk_run <= dbg_q;
					o_power.clkgen_on <= dbg_q;
					o_power.clkgen_standby <= !dbg_q;
					o_power.clkgen_keep_ref <= !dbg_q && keep_ref_q;
					o_power.regulator_full <= dbg_q || (lvd_q && lvd_stop_q);
					o_power.converter_standby <= 1'b1;
					o_power.pins_force_reset <= 1'b0;
					o_power.ram_keep <= 1'b1;
				end
				default: begin
					// Stop2 and stop1: everything off except RAM in stop2
					o_power.core_clk_run <= 1'b0;
					o_power.periph_clk_run <= 1'b0;
					o_power.debug_clk_run <= 1'b0;
					o_power.clkgen_on <= 1'b0;
					o_power.clkgen_standby <= 1'b0;
					o_power.clkgen_keep_ref <= 1'b0;
					o_power.regulator_full <= 1'b0;
					o_power.converter_standby <= 1'b1;
					o_power.pins_force_reset <= (mode_q == stop_ctrl_pkg::MODE_STOP1);
					o_power.ram_keep <= (mode_q == stop_ctrl_pkg::MODE_STOP2);
					o_power.keyboard_wake_en <= 1'b0;
				end
			endcase
		end
	end

	// ---------------------------------------------------------------
	// Debug status answers and visible state
	// ---------------------------------------------------------------
	always_ff @(posedge i_core_clk or negedge rstn) begin
		if (!rstn) begin
			o_debug_mem_grant <= 1'b0;
			o_debug_stop_error <= 1'b0;
			o_in_stop <= 1'b0;
			o_stop_mode <= stop_ctrl_pkg::MODE_RUN;
			o_wake_tick_running <= 1'b0;
			o_periodic_wakeup_interrupt <= 1'b0;
		end else begin
			o_debug_mem_grant <= i_debug_mem_status_cmd && (mode_q == stop_ctrl_pkg::MODE_RUN);
			o_debug_stop_error <= i_debug_mem_status_cmd && (mode_q != stop_ctrl_pkg::MODE_RUN);
			o_in_stop <= (mode_q != stop_ctrl_pkg::MODE_RUN);
			o_stop_mode <= mode_q;
			o_wake_tick_running <= tick_run;
			o_periodic_wakeup_interrupt <= tick;
		end
	end

endmodule
`default_nettype wire

// ---- sim/stop_ctrl_asserts.sv ----
// Port-level checks of the stop-mode power controller.
// Assumes one core clock domain and the active-low reset input.
`timescale 1ns/1ps
`default_nettype none
`include "stop_ctrl_consts.svh"
module stop_ctrl_asserts #(
	parameter int unsigned WAKE_TICK_CYCLES = 8
) (
	input wire logic i_core_clk,
	input wire logic i_rstn,
	input wire logic i_stop_instr,
	input wire logic i_stop_enable_bit,
	input wire logic i_debug_mem_status_cmd,
	input wire logic i_irq_pin,
	input wire logic i_reset_pin_n,
	input wire logic i_partial_powerdown_acknowledge,
	input wire logic [2:0] i_wakeup_period_select,
	input wire logic o_illegal_opcode_reset,
	input wire stop_ctrl_pkg::power_ctrl_t o_power,
	input wire stop_ctrl_pkg::wake_out_t o_wake,
	input wire logic o_in_stop,
	input wire stop_ctrl_pkg::stop_mode_t o_stop_mode,
	input wire logic o_debug_mem_grant,
	input wire logic o_debug_stop_error,
	input wire logic o_stop2_recovery_flag,
	input wire logic o_wake_tick_running,
	input wire logic o_periodic_wakeup_interrupt
);
	// ----------------------------------------
	// Checks in the core clock domain
	// ----------------------------------------
	default clocking @(posedge i_core_clk); endclocking
	default disable iff (!i_rstn);
	a_illegal_stop: assert property (i_stop_instr && !i_stop_enable_bit && !o_in_stop
		|=> o_illegal_opcode_reset ##1 !o_in_stop) else $error("stop without enable not refused");
	a_periph_halt: assert property (o_in_stop |-> !o_power.periph_clk_run && !o_power.core_clk_run)
		else $error("clocks running in stop");
	a_mem_refused: assert property (o_in_stop && !o_wake.wake && i_debug_mem_status_cmd
		|=> o_debug_stop_error && !o_debug_mem_grant) else $error("memory access granted in stop");
	a_irq_vector: assert property (o_wake.wake && $past(i_irq_pin) && $past(i_reset_pin_n)
		&& o_stop_mode == stop_ctrl_pkg::MODE_STOP3 |-> !o_wake.take_reset && o_wake.vector == `VEC_IRQ)
		else $error("irq wake vector wrong");
	a_reset_vector: assert property (o_wake.wake && !$past(i_reset_pin_n)
		|-> o_wake.take_reset && o_wake.vector == `VEC_RESET) else $error("reset wake vector wrong");
	a_kbd_off: assert property (o_in_stop && o_stop_mode != stop_ctrl_pkg::MODE_STOP3
		|-> !o_power.keyboard_wake_en) else $error("keyboard wake live in deep stop");
	a_tick_off: assert property ($past(i_wakeup_period_select) == 3'h0 && i_wakeup_period_select == 3'h0
		|=> !o_wake_tick_running && !o_periodic_wakeup_interrupt) else $error("tick source not off");
	a_recov_hold: assert property (o_stop2_recovery_flag && !i_partial_powerdown_acknowledge
		&& !$past(i_partial_powerdown_acknowledge) |=> o_stop2_recovery_flag && o_power.pins_latched)
		else $error("recovery flag or pin latch dropped");
endmodule
bind stop_mode_power_control stop_ctrl_asserts #(.WAKE_TICK_CYCLES(WAKE_TICK_CYCLES)) i_stop_ctrl_asserts (.*);
`default_nettype wire

// ---- sim/test_stop_mode_power_control.sv ----
// Self-checking bench for the stop-mode power controller.
// Assumes the wake pins model and the bound checker are compiled alongside.
`timescale 1ns/1ps
`default_nettype none
`include "stop_ctrl_consts.svh"
module test_stop_mode_power_control;
	logic clk = 1'b0, rstn = 1'b0, stop_instr = 1'b0, stop_en = 1'b1, ack = 1'b0;
	logic dbg = 1'b0, low_voltage_detect_enable = 1'b0, low_voltage_detect_stop_enable = 1'b0, keep_ref = 1'b0, got_err, got_bg, got_tick;
	logic [1:0] sel = 2'h0;
	logic [2:0] wps = 3'h0, cmd = 3'h0;
	logic [7:0] kbd_en = 8'h00, kbd_val = 8'h00, kbd;
	logic rst_pin_n, irq, bg_cmd, mem_cmd, illegal, in_stop, grant, serr, bg_entry, recov, tick_run, tick_irq;
	stop_ctrl_pkg::power_ctrl_t pwr;
	stop_ctrl_pkg::wake_out_t wk, got_w;
	stop_ctrl_pkg::stop_mode_t mode;
	int bad_count = 0, compares = 0;
	logic [31:0] seed = 32'h5dfb19e1;
	always #2 clk = ~clk;
	// Short tick count keeps periodic wakes within 8 cycles
	stop_mode_power_control #(.WAKE_TICK_CYCLES(8)) i_stop_mode_power_control (.i_core_clk(clk), .i_rstn(rstn),
		.i_stop_instr(stop_instr), .i_stop_enable_bit(stop_en), .i_stop_select(sel), .i_debug_mode_enable(dbg),
		.i_low_voltage_detect_enable(low_voltage_detect_enable), .i_low_voltage_detect_stop_enable(low_voltage_detect_stop_enable), .i_clkgen_keep_ref(keep_ref),
		.i_wakeup_period_select(wps), .i_reset_pin_n(rst_pin_n), .i_irq_pin(irq), .i_keyboard_pins(kbd),
		.i_keyboard_enable(kbd_en), .i_debug_background_cmd(bg_cmd), .i_debug_mem_status_cmd(mem_cmd),
		.i_partial_powerdown_acknowledge(ack), .o_illegal_opcode_reset(illegal), .o_power(pwr), .o_wake(wk),
		.o_in_stop(in_stop), .o_stop_mode(mode), .o_debug_mem_grant(grant), .o_debug_stop_error(serr),
		.o_background_entry(bg_entry), .o_stop2_recovery_flag(recov), .o_wake_tick_running(tick_run),
		.o_periodic_wakeup_interrupt(tick_irq));
	wake_pins_model i_wake_pins_model (.i_clk(clk), .i_cmd(cmd), .i_kbd(kbd_val), .o_reset_pin_n(rst_pin_n),
		.o_irq(irq), .o_kbd(kbd), .o_bg_cmd(bg_cmd), .o_mem_cmd(mem_cmd));
	// ----------------------------------------
	// Expectations and helpers
	// ----------------------------------------
	function automatic logic [31:0] xs();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed;
	endfunction
	function automatic stop_ctrl_pkg::stop_mode_t exp_mode(input logic [1:0] s, input logic d, input logic l);
		if (d || l || s == `STOP_REQ_STOP3 || s == 2'h3) return stop_ctrl_pkg::MODE_STOP3;
		return (s == `STOP_REQ_STOP2) ? stop_ctrl_pkg::MODE_STOP2 : stop_ctrl_pkg::MODE_STOP1;
	endfunction
	// Field order follows the power struct, core clock first
	function automatic stop_ctrl_pkg::power_ctrl_t exp_pwr(input stop_ctrl_pkg::stop_mode_t m, input logic d,
		input logic r, input logic k);
		logic s3;
		s3 = m == stop_ctrl_pkg::MODE_STOP3;
		return {2'b00, d, d, s3 && !d, s3 && !d && k, d || r, 1'b1, m == stop_ctrl_pkg::MODE_STOP2,
			m == stop_ctrl_pkg::MODE_STOP1, m != stop_ctrl_pkg::MODE_STOP1, s3};
	endfunction
	function automatic logic [15:0] exp_vec(input logic [2:0] c);
		case (c)
			3'h2: return `VEC_IRQ;
			3'h3: return `VEC_KEYBOARD;
			3'h6: return `VEC_PERIODIC;
			default: return `VEC_RESET;
		endcase
	endfunction
	task automatic chk(input string name, input logic [19:0] exp, input logic [19:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", name, exp, got);
		end
	endtask
	// Sends one far-side command, then watches n cycles for the answers
	task automatic run_cmd(input logic [2:0] c, input int n);
		cmd = c;
		got_w = '0;
		got_err = 1'b0;
		got_bg = 1'b0;
		got_tick = 1'b0;
		@(posedge clk);
		#1 cmd = 3'h0;
		repeat (n) begin
			@(posedge clk);
			#1;
			if (wk.wake) got_w = wk;
			if (serr) got_err = 1'b1;
			if (bg_entry) got_bg = 1'b1;
			if (tick_irq) got_tick = 1'b1;
		end
	endtask
	// One stop entry with the given settings, ended by wake cause c
	task automatic run_stop(input logic [1:0] s, input logic d, input logic le, input logic ls, input logic [2:0] c);
		stop_ctrl_pkg::stop_mode_t m;
		logic [31:0] r;
		logic tr;
		r = xs();
		m = exp_mode(s, d, ls);
		sel = s;
		dbg = d;
		low_voltage_detect_enable = le;
		low_voltage_detect_stop_enable = ls;
		keep_ref = r[16];
		kbd_val = r[7:0] | 8'h01;
		kbd_en = r[15:8] | 8'h01;
		wps = (c == 3'h6) ? (r[19:17] | 3'h1) : 3'h0;
		stop_instr = 1'b1;
		@(posedge clk);
		#1 stop_instr = 1'b0;
		repeat (2) @(posedge clk);
		#1;
		if (c != 3'h6) begin
			chk("stop_mode", m, mode);
			chk("power", exp_pwr(m, d, le && ls, r[16]), pwr);
			chk("tick_running", 0, tick_run);
		end
		if (c == 3'h4) begin
			run_cmd(3'h5, 4);
			chk("stop_error", 1, got_err);
			run_cmd(3'h4, 8);
			chk("background", d, got_bg);
			chk("in_stop", !d, in_stop);
			c = d ? 3'h7 : 3'h2;
		end
		if (c != 3'h7) run_cmd(c, (c == 3'h6) ? 3000 : 8);
		if (c == 3'h6) chk("tick_running", 1, tick_run);
		if (c == 3'h6) chk("tick_irq", 1, got_tick);
		wps = 3'h0;
		chk("in_stop", 0, in_stop);
		tr = (m != stop_ctrl_pkg::MODE_STOP3) || (c == 3'h1);
		if (c != 3'h7) chk("wake", {1'b1, tr, tr ? `VEC_RESET : exp_vec(c)},
			{got_w.wake, got_w.take_reset, got_w.vector});
		if (c != 3'h7) chk("periph_reset", m != stop_ctrl_pkg::MODE_STOP3, got_w.periph_reset);
		if (m == stop_ctrl_pkg::MODE_STOP2) begin
			chk("recovery", 2'b11, {recov, pwr.pins_latched});
			ack = 1'b1;
			@(posedge clk);
			#1 ack = 1'b0;
			repeat (2) @(posedge clk);
			#1 chk("recovered", 2'b00, {recov, pwr.pins_latched});
		end
		$display("stop request %0d cause %0d done", s, c);
	endtask
	task automatic print_verdict();
		$display("comparisons %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	// Watchdog: far beyond the few thousand cycles the tests need
	initial begin
		#160000;
		bad_count++;
		print_verdict();
	end
	// ----------------------------------------
	// Main sequence
	// ----------------------------------------
	initial begin
		logic [31:0] r;
		repeat (16) @(posedge clk);
		#1 rstn = 1'b1;
		repeat (4) @(posedge clk);
		#1 stop_en = 1'b0;
		stop_instr = 1'b1;
		@(posedge clk);
		#1 stop_instr = 1'b0;
		chk("illegal", 1, illegal);
		@(posedge clk);
		#1 chk("illegal_pulse", 0, illegal);
		repeat (2) @(posedge clk);
		#1 chk("in_stop", 0, in_stop);
		stop_en = 1'b1;
		// Status access in run is granted, not refused
		cmd = 3'h5;
		@(posedge clk);
		#1 cmd = 3'h0;
		@(posedge clk);
		#1 chk("mem_grant", 2'b10, {grant, serr});
		$display("illegal stop and run access done");
		run_stop(2'h0, 0, 0, 0, 3'h4);
		run_stop(2'h0, 0, 0, 0, 3'h3);
		run_stop(2'h3, 0, 0, 0, 3'h1);
		run_stop(2'h1, 0, 0, 0, 3'h2);
		run_stop(2'h2, 0, 0, 0, 3'h1);
		run_stop(2'h1, 1, 0, 0, 3'h4);
		run_stop(2'h2, 0, 1, 1, 3'h2);
		run_stop(2'h0, 0, 0, 0, 3'h6);
		for (int i = 0; i < 8; i++) begin
			r = xs();
			run_stop(r[1:0], r[2], r[3], r[4], r[5] ? 3'h2 : 3'h1);
		end
		print_verdict();
	end
endmodule
`default_nettype wire

// ---- sim/wake_pins_model.sv ----
// Far-side model: wake pins and the serial debug host.
// Assumes commands arrive one cycle long, just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module wake_pins_model (
	input wire logic i_clk,
	input wire logic [2:0] i_cmd,
	input wire logic [7:0] i_kbd,
	output logic o_reset_pin_n,
	output logic o_irq,
	output logic [7:0] o_kbd,
	output logic o_bg_cmd,
	output logic o_mem_cmd
);
	logic [2:0] code_q = 3'h0;
	logic [2:0] cmd_q = 3'h0;
	logic [1:0] hold_q = 2'h0;
	// Pin levels stand a few cycles then release to their pull levels
	// Non-blocking so the block under test never races the model at the edge
	always @(posedge i_clk) begin
		cmd_q <= i_cmd;
		if (i_cmd != 3'h0) begin
			code_q <= i_cmd;
			hold_q <= 2'h3;
		end else if (hold_q != 2'h0)
			hold_q <= hold_q - 2'h1;
		else
			code_q <= 3'h0;
	end
	// Reset pin is pulled up, irq and keyboard lines pulled down
	assign o_reset_pin_n = code_q != 3'h1;
	assign o_irq = code_q == 3'h2;
	assign o_kbd = (code_q == 3'h3) ? i_kbd : 8'h00;
	// Debug host commands are single-cycle pulses
	assign o_bg_cmd = cmd_q == 3'h4;
	assign o_mem_cmd = cmd_q == 3'h5;
endmodule
`default_nettype wire
